// File: common/error_status_word_bank_map.vh
// Word offsets, field positions, fixed values and codes of the error status word bank.
`ifndef ERROR_STATUS_WORD_BANK_MAP_VH
`define ERROR_STATUS_WORD_BANK_MAP_VH

// ****************************************
// Word offsets
// ****************************************
`define OFS_FAULT_SUMMARY 9'h191
`define OFS_ALARM_SUMMARY 9'h192
`define OFS_MEMORY_FAULT_FLAGS 9'h193
`define OFS_BUS_ERROR_LOCATION 9'h194
`define OFS_SETUP_ERROR_ADDRESS 9'h196
`define OFS_POINT_OVERFLOW_INFO 9'h197
`define OFS_BUS_UNIT_DUPLICATE_MAP 9'h19A
`define OFS_SPECIAL_UNIT_DUPLICATE_MAP 9'h19B
`define OFS_BUS_UNIT_ERROR_MAP 9'h1A1
`define OFS_SPECIAL_UNIT_ERROR_MAP 9'h1A2
`define OFS_IO_AREA_IDENTIFIER 9'h1C2
`define OFS_WORK_AREA_IDENTIFIER 9'h1C3
`define OFS_HOLDING_AREA_IDENTIFIER 9'h1C4
`define OFS_INDEX_AREA_IDENTIFIER 9'h1CB
`define OFS_DATA_AREA_IDENTIFIER 9'h1CC
`define OFS_CAPTURE_CONTROL 9'h1D0
`define SPECIAL_MAP_WORDS 9'h006

// ****************************************
// Bit positions
// ****************************************
`define BIT_DUPLICATION_SUMMARY 13
`define BIT_NONFATAL_USER_ALARM 15
`define BIT_BUS_UNIT_ERROR_SUMMARY 7
`define BIT_SPECIAL_UNIT_ERROR_SUMMARY 6
`define BIT_USER_PROGRAM_MEMORY 0
`define BIT_SETUP_PARAMETER 4
`define BIT_FLASH_DAMAGED 10
`define BIT_CALIBRATION_INVALID 13
`define BIT_BACKUP_CHECKSUM 14
`define BIT_CAPTURE_ENABLE 0

// ****************************************
// Fixed values and codes
// ****************************************
`define ID_GENERAL_IO_AREA 16'h00B0
`define ID_WORK_AREA 16'h00B1
`define ID_RETAINED_AREA 16'h00B2
`define ID_INDEX_AREA 16'h00DC
`define ID_DATA_MEMORY_AREA 16'h0082
`define LOC_COVER_MISSING 8'h0E
`define LOC_UNKNOWN 8'h0F
`define LOC_SLOT_LAST 8'h09
`define LOC_RACK_LAST 8'h01
`define CAUSE_IO_POINTS 3'h1
`define CAUSE_INTERRUPT_INPUTS 3'h2
`define CAUSE_EXPANSION_RACKS 3'h3
`define INTERRUPT_INPUT_LIMIT 13'h0020
`define SPECIAL_UNIT_FIRST_LEGAL 7'h0A
`define SPECIAL_UNIT_COUNT 7'h60
`define CAPTURE_RESET 1'b1

`endif

// File: core/error_status_word_bank.v
// Error status word bank: latches detected faults and exposes them as read-only words.
`include "error_status_word_bank_map.vh"

module error_status_word_bank #(
    parameter MAX_IO_POINTS = 13'd640,
    parameter MAX_EXP_RACKS = 13'd1
) (
    // Clock and reset
    input wire mclk_i,
    input wire reset_i,
    // Register port
    input wire [8:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [15:0] reg_rdata_o,
    // Non-fatal user alarm
    input wire nonfatal_user_alarm_set_i,
    input wire nonfatal_user_alarm_clr_i,
    // Memory faults: um, setup, flash damaged, calibration, checksum
    input wire [4:0] mem_fault_set_i,
    input wire [4:0] mem_fault_clr_i,
    // Setup parameter error location
    input wire [15:0] setup_err_addr_i,
    // Bus error location
    input wire bus_err_valid_i,
    input wire [7:0] bus_err_slot_i,
    input wire [7:0] bus_err_rack_i,
    input wire bus_err_cover_missing_i,
    input wire bus_err_unknown_i,
    input wire bus_err_clr_i,
    // Configuration check for too many points
    input wire cfg_check_i,
    input wire [12:0] cfg_io_points_i,
    input wire [12:0] cfg_int_inputs_i,
    input wire [12:0] cfg_exp_racks_i,
    input wire overflow_clr_i,
    // Unit number duplication
    input wire bus_dup_valid_i,
    input wire [3:0] bus_dup_unit_i,
    input wire spec_assign_valid_i,
    input wire [6:0] spec_assign_unit_i,
    input wire spec_assign_dup_i,
    input wire dup_clr_i,
    // Data exchange errors
    input wire bus_xfer_err_i,
    input wire [3:0] bus_xfer_unit_i,
    input wire spec_xfer_err_i,
    input wire [6:0] spec_xfer_unit_i,
    input wire xfer_clr_i,
    // Status
    output wire capture_enable_o
);

    // ****************************************
    // Capture control
    // ****************************************
    // Software may freeze capture so a fault picture stays steady while it is read.
    reg capture_reg;
    wire capture_next;

    assign capture_next = (reg_wr_i && reg_addr_i == `OFS_CAPTURE_CONTROL) ?
        reg_wdata_i[`BIT_CAPTURE_ENABLE] : capture_reg;
    assign capture_enable_o = capture_reg;

    always @(posedge mclk_i) begin
        if (reset_i) begin
            capture_reg <= `CAPTURE_RESET;
        end else begin
            capture_reg <= capture_next;
        end
    end

    // ****************************************
    // Non-fatal user alarm
    // ****************************************
    reg alarm_reg;
    wire alarm_next;

    // Set wins over clear so an alarm in the clearing cycle is kept.
    assign alarm_next = (capture_reg && nonfatal_user_alarm_set_i) ? 1'b1 :
        (nonfatal_user_alarm_clr_i ? 1'b0 : alarm_reg);

    always @(posedge mclk_i) begin
        if (reset_i) begin
            alarm_reg <= 1'b0;
        end else begin
            alarm_reg <= alarm_next;
        end
    end

    // ****************************************
    // Memory fault flags
    // ****************************************
    reg [4:0] mem_fault_reg;
    wire [4:0] mem_fault_next;
    wire [15:0] mem_fault_word;

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : mem_bits
            assign mem_fault_next[g] = (capture_reg && mem_fault_set_i[g]) ? 1'b1 :
                (mem_fault_clr_i[g] ? 1'b0 : mem_fault_reg[g]);
        end
    endgenerate

    always @(posedge mclk_i) begin
        if (reset_i) begin
            mem_fault_reg <= 5'h00;
        end else begin
            mem_fault_reg <= mem_fault_next;
        end
    end

    assign mem_fault_word = (16'h0001 << `BIT_USER_PROGRAM_MEMORY) &
        {16{mem_fault_reg[0]}} |
        (16'h0001 << `BIT_SETUP_PARAMETER) & {16{mem_fault_reg[1]}} |
        (16'h0001 << `BIT_FLASH_DAMAGED) & {16{mem_fault_reg[2]}} |
        (16'h0001 << `BIT_CALIBRATION_INVALID) & {16{mem_fault_reg[3]}} |
        (16'h0001 << `BIT_BACKUP_CHECKSUM) & {16{mem_fault_reg[4]}};

    // ****************************************
    // Setup error location
    // ****************************************
    reg [15:0] setup_addr_reg;
    wire [15:0] setup_addr_next;

    assign setup_addr_next = (capture_reg && mem_fault_set_i[1]) ? setup_err_addr_i :
        (mem_fault_clr_i[1] ? 16'h0000 : setup_addr_reg);

    always @(posedge mclk_i) begin
        if (reset_i) begin
            setup_addr_reg <= 16'h0000;
        end else begin
            setup_addr_reg <= setup_addr_next;
        end
    end

    // ****************************************
    // Bus error location
    // ****************************************
    reg [7:0] slot_reg;
    reg [7:0] rack_reg;
    reg [7:0] slot_code;
    reg [7:0] rack_code;

    // A cover fault outranks an unknown location; out-of-range numbers read as unknown.
    always @* begin
        if (bus_err_cover_missing_i) begin
            slot_code = `LOC_COVER_MISSING;
            rack_code = `LOC_COVER_MISSING;
        end else if (bus_err_unknown_i) begin
            slot_code = `LOC_UNKNOWN;
            rack_code = `LOC_UNKNOWN;
        end else begin
            slot_code = (bus_err_slot_i > `LOC_SLOT_LAST) ? `LOC_UNKNOWN : bus_err_slot_i;
            rack_code = (bus_err_rack_i > `LOC_RACK_LAST) ? `LOC_UNKNOWN : bus_err_rack_i;
        end
    end

    always @(posedge mclk_i) begin
        if (reset_i) begin
            slot_reg <= 8'h00;
            rack_reg <= 8'h00;
        end else if (capture_reg && bus_err_valid_i) begin
            slot_reg <= slot_code;
            rack_reg <= rack_code;
        end else if (bus_err_clr_i) begin
            slot_reg <= 8'h00;
            rack_reg <= 8'h00;
        end
    end

    // ****************************************
    // Too many points
    // ****************************************
    reg [2:0] cause_reg;
    reg [12:0] detail_reg;
    reg [2:0] cause_next;
    reg [12:0] detail_next;
    wire [12:0] max_points;
    wire [12:0] max_racks;

    assign max_points = MAX_IO_POINTS;
    assign max_racks = MAX_EXP_RACKS;

    // When several limits are broken at once the point total is reported first.
    always @* begin
        cause_next = cause_reg;
        detail_next = detail_reg;
        if (capture_reg && cfg_check_i && cfg_io_points_i > max_points) begin
            cause_next = `CAUSE_IO_POINTS;
            detail_next = cfg_io_points_i;
        end else if (capture_reg && cfg_check_i &&
                     cfg_int_inputs_i > `INTERRUPT_INPUT_LIMIT) begin
            cause_next = `CAUSE_INTERRUPT_INPUTS;
            detail_next = cfg_int_inputs_i;
        end else if (capture_reg && cfg_check_i && cfg_exp_racks_i > max_racks) begin
            cause_next = `CAUSE_EXPANSION_RACKS;
            detail_next = cfg_exp_racks_i;
        end else if (overflow_clr_i) begin
            cause_next = 3'h0;
            detail_next = 13'h0000;
        end
    end

    always @(posedge mclk_i) begin
        if (reset_i) begin
            cause_reg <= 3'h0;
            detail_reg <= 13'h0000;
        end else begin
            cause_reg <= cause_next;
            detail_reg <= detail_next;
        end
    end

    // ****************************************
    // Unit duplication maps
    // ****************************************
    reg [15:0] bus_dup_reg;
    reg [95:0] spec_dup_reg;
    wire [15:0] bus_dup_set;
    wire [95:0] spec_dup_set;
    wire spec_dup_hit;

    assign bus_dup_set = (capture_reg && bus_dup_valid_i) ?
        (16'h0001 << bus_dup_unit_i) : 16'h0000;
    assign spec_dup_hit = capture_reg && spec_assign_valid_i &&
        spec_assign_unit_i < `SPECIAL_UNIT_COUNT &&
        (spec_assign_dup_i || spec_assign_unit_i < `SPECIAL_UNIT_FIRST_LEGAL);
    assign spec_dup_set = spec_dup_hit ?
        ({{95{1'b0}}, 1'b1} << spec_assign_unit_i) : {96{1'b0}};

    always @(posedge mclk_i) begin
        if (reset_i) begin
            bus_dup_reg <= 16'h0000;
            spec_dup_reg <= {96{1'b0}};
        end else if (dup_clr_i) begin
            bus_dup_reg <= bus_dup_set;
            spec_dup_reg <= spec_dup_set;
        end else begin
            bus_dup_reg <= bus_dup_reg | bus_dup_set;
            spec_dup_reg <= spec_dup_reg | spec_dup_set;
        end
    end

    // ****************************************
    // Data exchange error maps
    // ****************************************
    reg [15:0] bus_xfer_reg;
    reg [95:0] spec_xfer_reg;
    wire [15:0] bus_xfer_set;
    wire [95:0] spec_xfer_set;

    assign bus_xfer_set = (capture_reg && bus_xfer_err_i) ?
        (16'h0001 << bus_xfer_unit_i) : 16'h0000;
    // Unit numbers beyond the map are dropped rather than aliased onto a real unit.
    assign spec_xfer_set = (capture_reg && spec_xfer_err_i &&
        spec_xfer_unit_i < `SPECIAL_UNIT_COUNT) ?
        ({{95{1'b0}}, 1'b1} << spec_xfer_unit_i) : {96{1'b0}};

    always @(posedge mclk_i) begin
        if (reset_i) begin
            bus_xfer_reg <= 16'h0000;
            spec_xfer_reg <= {96{1'b0}};
        end else if (xfer_clr_i) begin
            bus_xfer_reg <= bus_xfer_set;
            spec_xfer_reg <= spec_xfer_set;
        end else begin
            bus_xfer_reg <= bus_xfer_reg | bus_xfer_set;
            spec_xfer_reg <= spec_xfer_reg | spec_xfer_set;
        end
    end

    // ****************************************
    // Summary words
    // ****************************************
    // Summaries are derived from the maps so they can never disagree with them.
    wire dup_summary;
    wire bus_xfer_summary;
    wire spec_xfer_summary;
    wire [15:0] fault_summary_word;
    wire [15:0] alarm_summary_word;

    assign dup_summary = |{bus_dup_reg, spec_dup_reg};
    assign bus_xfer_summary = |bus_xfer_reg;
    assign spec_xfer_summary = |spec_xfer_reg;
    assign fault_summary_word = (16'h0001 << `BIT_DUPLICATION_SUMMARY) & {16{dup_summary}};
    assign alarm_summary_word =
        (16'h0001 << `BIT_NONFATAL_USER_ALARM) & {16{alarm_reg}} |
        (16'h0001 << `BIT_BUS_UNIT_ERROR_SUMMARY) & {16{bus_xfer_summary}} |
        (16'h0001 << `BIT_SPECIAL_UNIT_ERROR_SUMMARY) & {16{spec_xfer_summary}};

    // ****************************************
    // Read path
    // ****************************************
    reg [15:0] read_word;
    wire [8:0] spec_dup_idx;
    wire [8:0] spec_xfer_idx;

    assign spec_dup_idx = reg_addr_i - `OFS_SPECIAL_UNIT_DUPLICATE_MAP;
    assign spec_xfer_idx = reg_addr_i - `OFS_SPECIAL_UNIT_ERROR_MAP;

    // Writes to any word but capture control are ignored, keeping status read-only.
    always @* begin
        read_word = 16'h0000;
        if (spec_dup_idx < `SPECIAL_MAP_WORDS) begin
            read_word = spec_dup_reg[{spec_dup_idx[2:0], 4'h0} +: 16];
        end else if (spec_xfer_idx < `SPECIAL_MAP_WORDS) begin
            read_word = spec_xfer_reg[{spec_xfer_idx[2:0], 4'h0} +: 16];
        end else begin
            case (reg_addr_i)
                `OFS_FAULT_SUMMARY: begin
                    read_word = fault_summary_word;
                end
                `OFS_ALARM_SUMMARY: begin
                    read_word = alarm_summary_word;
                end
                `OFS_MEMORY_FAULT_FLAGS: begin
                    read_word = mem_fault_word;
                end
                `OFS_BUS_ERROR_LOCATION: begin
                    read_word = {rack_reg, slot_reg};
                end
                `OFS_SETUP_ERROR_ADDRESS: begin
                    read_word = setup_addr_reg;
                end
                `OFS_POINT_OVERFLOW_INFO: begin
                    read_word = {cause_reg, detail_reg};
                end
                `OFS_BUS_UNIT_DUPLICATE_MAP: begin
                    read_word = bus_dup_reg;
                end
                `OFS_BUS_UNIT_ERROR_MAP: begin
                    read_word = bus_xfer_reg;
                end
                `OFS_IO_AREA_IDENTIFIER: begin
                    read_word = `ID_GENERAL_IO_AREA;
                end
                `OFS_WORK_AREA_IDENTIFIER: begin
                    read_word = `ID_WORK_AREA;
                end
                `OFS_HOLDING_AREA_IDENTIFIER: begin
                    read_word = `ID_RETAINED_AREA;
                end
                `OFS_INDEX_AREA_IDENTIFIER: begin
                    read_word = `ID_INDEX_AREA;
                end
                `OFS_DATA_AREA_IDENTIFIER: begin
                    read_word = `ID_DATA_MEMORY_AREA;
                end
                `OFS_CAPTURE_CONTROL: begin
                    read_word = {15'h0000, capture_reg};
                end
                default: begin
                    read_word = 16'h0000;
                end
            endcase
        end
    end

    // Read data stand only in the cycle after the strobe and are zero otherwise.
    always @(posedge mclk_i) begin
        if (reset_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= read_word;
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

endmodule

// File: dv/error_status_word_bank_sva.sv
// Checker of the register port and event capture of the error status word bank.
`include "error_status_word_bank_map.vh"

module error_status_word_bank_sva (
    // Clock and reset
    input wire mclk_i,
    input wire reset_i,
    // Register port
    input wire [8:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [15:0] reg_rdata_o,
    // Events and status
    input wire nonfatal_user_alarm_set_i,
    input wire [4:0] mem_fault_set_i,
    input wire bus_err_valid_i,
    input wire bus_err_cover_missing_i,
    input wire spec_xfer_err_i,
    input wire [6:0] spec_xfer_unit_i,
    input wire capture_enable_o
);
    // ********
    // Properties
    // ********
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    sequence rd_at(logic [8:0] a);
        reg_rd_i && reg_addr_i == a;
    endsequence

    chk_idle_rdata: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("read data not zero outside a read");
    chk_io_ident: assert property (rd_at(`OFS_IO_AREA_IDENTIFIER) |=> reg_rdata_o == 16'h00B0)
        else $error("io area identifier wrong");
    chk_data_ident: assert property (rd_at(`OFS_DATA_AREA_IDENTIFIER) |=> reg_rdata_o == 16'h0082)
        else $error("data area identifier wrong");
    // The enable is judged as it stood at the event edge, as the capture logic sees it.
    chk_alarm_latch: assert property (nonfatal_user_alarm_set_i && capture_enable_o
        ##1 rd_at(`OFS_ALARM_SUMMARY) |=> reg_rdata_o[15])
        else $error("alarm flag not set");
    chk_prog_mem_latch: assert property (mem_fault_set_i[0] && capture_enable_o
        ##1 rd_at(`OFS_MEMORY_FAULT_FLAGS) |=> reg_rdata_o[0])
        else $error("program memory flag not set");
    chk_cover_code: assert property (bus_err_valid_i && bus_err_cover_missing_i
        && capture_enable_o ##1 rd_at(`OFS_BUS_ERROR_LOCATION) |=> reg_rdata_o == 16'h0E0E)
        else $error("cover missing code wrong");
    chk_spec_summary: assert property (spec_xfer_err_i && capture_enable_o
        && spec_xfer_unit_i < 7'h60 ##1 rd_at(`OFS_ALARM_SUMMARY) |=> reg_rdata_o[6])
        else $error("special unit summary not set");
    chk_ro_write: assert property (reg_wr_i && reg_addr_i != `OFS_CAPTURE_CONTROL
        |=> $stable(capture_enable_o))
        else $error("write elsewhere changed capture enable");
    chk_capture_rst: assert property ($fell(reset_i) |-> capture_enable_o)
        else $error("capture enable not set after reset");

    cover property (reg_wr_i && reg_addr_i == `OFS_CAPTURE_CONTROL && !reg_wdata_i[0]);
    cover property (nonfatal_user_alarm_set_i && !capture_enable_o);
    cover property (spec_xfer_err_i && spec_xfer_unit_i > 7'h5F);
endmodule

bind error_status_word_bank error_status_word_bank_sva i_sva (.mclk_i, .reset_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .nonfatal_user_alarm_set_i,
    .mem_fault_set_i, .bus_err_valid_i, .bus_err_cover_missing_i, .spec_xfer_err_i,
    .spec_xfer_unit_i, .capture_enable_o);

// File: dv/error_status_word_bank_tb.sv
// Self-checking testbench of the error status word bank against a reference model.
`include "error_status_word_bank_map.vh"

module error_status_word_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ********
    // Signals
    // ********
    localparam logic [12:0] IO_MAX = 13'h0280;
    localparam logic [12:0] RACK_MAX = 13'h0001;
    logic mclk_i, reset_i, reg_wr_i, reg_rd_i, capture_enable_o;
    logic [8:0] reg_addr_i, paddr;
    logic [15:0] reg_wdata_i, reg_rdata_o, setup_err_addr_i;
    logic nonfatal_user_alarm_set_i, nonfatal_user_alarm_clr_i, bus_err_valid_i;
    logic bus_err_cover_missing_i, bus_err_unknown_i, bus_err_clr_i, cfg_check_i;
    logic overflow_clr_i, bus_dup_valid_i, spec_assign_valid_i, spec_assign_dup_i;
    logic dup_clr_i, bus_xfer_err_i, spec_xfer_err_i, xfer_clr_i;
    logic [4:0] mem_fault_set_i, mem_fault_clr_i, mem;
    logic [7:0] bus_err_slot_i, bus_err_rack_i;
    logic [12:0] cfg_io_points_i, cfg_int_inputs_i, cfg_exp_racks_i, tio, tint, trk;
    logic [3:0] bus_dup_unit_i, bus_xfer_unit_i;
    logic [6:0] spec_assign_unit_i, spec_xfer_unit_i;
    logic [15:0] sa, loc, ov, bdup, berr, pexp;
    logic [95:0] sdup, serr;
    bit alarm, cap, pend, armed;
    int failures, checked, cycles;

    error_status_word_bank #(.MAX_IO_POINTS(IO_MAX), .MAX_EXP_RACKS(RACK_MAX)) i_dut (
        .mclk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .nonfatal_user_alarm_set_i, .nonfatal_user_alarm_clr_i, .mem_fault_set_i,
        .mem_fault_clr_i, .setup_err_addr_i, .bus_err_valid_i, .bus_err_slot_i,
        .bus_err_rack_i, .bus_err_cover_missing_i, .bus_err_unknown_i, .bus_err_clr_i,
        .cfg_check_i, .cfg_io_points_i, .cfg_int_inputs_i, .cfg_exp_racks_i, .overflow_clr_i,
        .bus_dup_valid_i, .bus_dup_unit_i, .spec_assign_valid_i, .spec_assign_unit_i,
        .spec_assign_dup_i, .dup_clr_i, .bus_xfer_err_i, .bus_xfer_unit_i, .spec_xfer_err_i,
        .spec_xfer_unit_i, .xfer_clr_i, .capture_enable_o
    );

    // ********
    // Tasks
    // ********
    function automatic bit p(input int n);
        return $urandom % n == 0;
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Mode 0 idles, 1 randomises, 2 fires the alarm, memory, bus error and special exchange captures at once, 3 runs a point check.
    // Data fields stay random even when idle so stale values never mask a fault.
    task automatic cyc(input int m, input logic [8:0] ra);
        int op;
        bit r;
        bit s;
        op = m == 1 ? $urandom % 8 : 7;
        r = m == 1;
        s = m == 2;
        nonfatal_user_alarm_set_i <= s || r && p(8);
        nonfatal_user_alarm_clr_i <= r && p(32);
        mem_fault_set_i <= s ? 5'h1F : r && p(4) ? 5'($urandom) : 5'h00;
        mem_fault_clr_i <= r && p(8) ? 5'($urandom) : 5'h00;
        setup_err_addr_i <= 16'($urandom);
        bus_err_valid_i <= s || r && p(8);
        bus_err_slot_i <= 8'($urandom % 16);
        bus_err_rack_i <= 8'($urandom % 4);
        bus_err_cover_missing_i <= s || p(4);
        bus_err_unknown_i <= p(4);
        bus_err_clr_i <= r && p(32);
        cfg_check_i <= m == 3 || r && p(8);
        cfg_io_points_i <= m == 3 ? tio : 13'($urandom);
        cfg_int_inputs_i <= m == 3 ? tint : 13'($urandom % 64);
        cfg_exp_racks_i <= m == 3 ? trk : 13'($urandom_range(8191, 2));
        overflow_clr_i <= r && p(32);
        bus_dup_valid_i <= r && p(8);
        bus_dup_unit_i <= 4'($urandom);
        spec_assign_valid_i <= r && p(4);
        spec_assign_unit_i <= 7'($urandom);
        spec_assign_dup_i <= p(2);
        dup_clr_i <= r && p(64);
        bus_xfer_err_i <= r && p(8);
        bus_xfer_unit_i <= 4'($urandom);
        spec_xfer_err_i <= s || r && p(4);
        spec_xfer_unit_i <= s ? 7'h11 : 7'($urandom);
        xfer_clr_i <= r && p(64);
        reg_rd_i <= ra != 9'h000 || op < 2;
        reg_wr_i <= op == 2;
        reg_addr_i <= ra != 9'h000 ? ra
            : op == 2 && p(2) ? `OFS_CAPTURE_CONTROL : 9'(9'h190 + $urandom % 68);
        reg_wdata_i <= {15'($urandom), !p(4)};
    endtask

    task sweep;
        for (int a = 'h190; a < 'h1D2; a++) begin
            @(posedge mclk_i);
            cyc(0, a[8:0]);
        end
        @(posedge mclk_i);
        cyc(0, 9'h000);
    endtask

    task results;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    function automatic logic [15:0] expw(input logic [8:0] a);
        logic [15:0] w;
        w = 16'h0000;
        case (a)
            `OFS_FAULT_SUMMARY: w = {2'b00, |bdup || |sdup, 13'h0000};
            `OFS_ALARM_SUMMARY: w = {alarm, 7'h00, |berr, |serr, 6'h00};
            `OFS_MEMORY_FAULT_FLAGS: w = {1'b0, mem[4:3], 2'b00, mem[2], 5'h00, mem[1], 3'h0, mem[0]};
            `OFS_BUS_ERROR_LOCATION: w = loc;
            `OFS_SETUP_ERROR_ADDRESS: w = sa;
            `OFS_POINT_OVERFLOW_INFO: w = ov;
            `OFS_BUS_UNIT_DUPLICATE_MAP: w = bdup;
            `OFS_BUS_UNIT_ERROR_MAP: w = berr;
            `OFS_IO_AREA_IDENTIFIER: w = 16'h00B0;
            `OFS_WORK_AREA_IDENTIFIER: w = 16'h00B1;
            `OFS_HOLDING_AREA_IDENTIFIER: w = 16'h00B2;
            `OFS_INDEX_AREA_IDENTIFIER: w = 16'h00DC;
            `OFS_DATA_AREA_IDENTIFIER: w = 16'h0082;
            `OFS_CAPTURE_CONTROL: w = {15'h0000, cap};
            default: begin
                if (a >= 9'h19B && a < 9'h1A1)
                    w = sdup[16 * (a - 9'h19B) +: 16];
                if (a >= 9'h1A2 && a < 9'h1A8)
                    w = serr[16 * (a - 9'h1A2) +: 16];
            end
        endcase
        return w;
    endfunction

    // ********
    // Reference model
    // ********
    // Inputs are read at the edge before the bench's own updates land, as the design sees them.
    always @(posedge mclk_i) begin
        if (armed && pend)
            check($sformatf("word %h", paddr), reg_rdata_o, pexp);
        else if (armed)
            check("idle read data", reg_rdata_o, 16'h0000);
        if (armed)
            check("capture enable", 16'(capture_enable_o), 16'(cap));
        armed = armed || reset_i;
        pend = reg_rd_i && !reset_i;
        paddr = reg_addr_i;
        pexp = expw(reg_addr_i);
        if (reset_i) begin
            {alarm, mem, sa, loc, ov, bdup, berr, sdup, serr} = '0;
            cap = 1'b1;
        end else begin
            if (nonfatal_user_alarm_clr_i)
                alarm = 1'b0;
            if (cap && nonfatal_user_alarm_set_i)
                alarm = 1'b1;
            mem = mem & ~mem_fault_clr_i;
            if (mem_fault_clr_i[1])
                sa = 16'h0000;
            if (cap)
                mem = mem | mem_fault_set_i;
            if (cap && mem_fault_set_i[1])
                sa = setup_err_addr_i;
            if (bus_err_clr_i)
                loc = 16'h0000;
            if (cap && bus_err_valid_i)
                loc = bus_err_cover_missing_i ? 16'h0E0E : bus_err_unknown_i ? 16'h0F0F
                    : {bus_err_rack_i > 8'h01 ? 8'h0F : bus_err_rack_i,
                       bus_err_slot_i > 8'h09 ? 8'h0F : bus_err_slot_i};
            if (overflow_clr_i)
                ov = 16'h0000;
            if (cap && cfg_check_i)
                ov = cfg_io_points_i > IO_MAX ? {3'h1, cfg_io_points_i}
                    : cfg_int_inputs_i > 13'h0020 ? {3'h2, cfg_int_inputs_i}
                    : cfg_exp_racks_i > RACK_MAX ? {3'h3, cfg_exp_racks_i} : 16'h0000;
            if (dup_clr_i)
                {bdup, sdup} = '0;
            if (cap && bus_dup_valid_i)
                bdup[bus_dup_unit_i] = 1'b1;
            if (cap && spec_assign_valid_i && spec_assign_unit_i < 7'h60
                    && (spec_assign_dup_i || spec_assign_unit_i < 7'h0A))
                sdup[spec_assign_unit_i] = 1'b1;
            if (xfer_clr_i)
                {berr, serr} = '0;
            if (cap && bus_xfer_err_i)
                berr[bus_xfer_unit_i] = 1'b1;
            if (cap && spec_xfer_err_i && spec_xfer_unit_i < 7'h60)
                serr[spec_xfer_unit_i] = 1'b1;
            if (reg_wr_i && reg_addr_i == `OFS_CAPTURE_CONTROL)
                cap = reg_wdata_i[0];
        end
    end

    // ********
    // Clock, timeout and sequence
    // ********
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            results();
        end
    end

    initial begin
        logic [8:0] da[4] = '{9'h192, 9'h193, 9'h194, 9'h1A3};
        logic [12:0] io_t[4] = '{13'h0281, 13'h0280, 13'h0280, 13'h1FFF};
        logic [12:0] in_t[4] = '{13'h0021, 13'h0021, 13'h0020, 13'h003F};
        logic [12:0] rk_t[4] = '{13'h0002, 13'h0002, 13'h0002, 13'h1FFF};
        void'($urandom(4));
        reset_i = 1'b1;
        cyc(0, 9'h000);
        repeat (16) @(posedge mclk_i);
        reset_i <= 1'b0;
        sweep();
        foreach (da[i]) begin
            @(posedge mclk_i);
            cyc(2, 9'h000);
            @(posedge mclk_i);
            cyc(0, da[i]);
        end
        // Point and interrupt limits sit on the boundary so one count too many or too few shows up; racks are only tried at 2 and above.
        foreach (io_t[i]) begin
            tio = io_t[i];
            tint = in_t[i];
            trk = rk_t[i];
            @(posedge mclk_i);
            cyc(3, 9'h000);
            @(posedge mclk_i);
            cyc(0, `OFS_POINT_OVERFLOW_INFO);
        end
        repeat (4000) begin
            @(posedge mclk_i);
            cyc(1, 9'h000);
        end
        sweep();
        reset_i <= 1'b1;
        repeat (16) @(posedge mclk_i);
        reset_i <= 1'b0;
        sweep();
        results();
    end
endmodule
